// >>> common/dsc_consts.svh
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH

// serial word layout
`define DSC_WORD_W        16
`define DSC_ADDR_HI       10
`define DSC_ADDR_LO       9
`define DSC_LOAD_BIT      8
`define DSC_CODE_HI       7
`define DSC_CODE_LO       0

// control_reg_a fields
`define DSC_A_MUTE        0
`define DSC_A_DEEMPH      1
`define DSC_A_DISABLE     2
`define DSC_A_WL_LO       3
`define DSC_A_WL_HI       4
`define DSC_A_RATE        5
`define DSC_A_GAIN        6
`define DSC_A_HID_LO      7
`define DSC_A_HID_HI      8

// control_reg_b fields
`define DSC_B_FMT         0
`define DSC_B_POL         1
`define DSC_B_COMMON      2
`define DSC_B_PHASE       4
`define DSC_B_CKO         5
`define DSC_B_SF_LO       6
`define DSC_B_SF_HI       7
`define DSC_B_ZD          8

// reset values (attenuation 0 dB, de-emphasis rate 44.1 kHz)
`define DSC_RST_LEFT      16'h00ff
`define DSC_RST_RIGHT     16'h02ff
`define DSC_RST_CTRL_A    16'h0400
`define DSC_RST_CTRL_B    16'h0680
`define DSC_RST_LEVEL     8'hff
`define DSC_MUTE_CODE     8'h00

// zero detect run, in serial bit clock cycles
`define DSC_ZERO_RUN      65536
`define DSC_RUN_W         24

`endif

// >>> common/dsc_pkg.sv
package dsc_pkg;

    typedef enum logic [1:0] {
        DSC_SEL_LEFT  = 2'b00,
        DSC_SEL_RIGHT = 2'b01,
        DSC_SEL_CTRLA = 2'b10,
        DSC_SEL_CTRLB = 2'b11
    } dsc_sel_t;

    typedef enum logic [2:0] {
        DSC_FMT_STD16 = 3'b000,
        DSC_FMT_STD20 = 3'b001,
        DSC_FMT_STD24 = 3'b010,
        DSC_FMT_LJ24  = 3'b011,
        DSC_FMT_SER16 = 3'b100,
        DSC_FMT_SER24 = 3'b101,
        DSC_FMT_RSVD  = 3'b110
    } dsc_fmt_t;

    typedef struct packed {
        logic        sck_prev;
        logic        latch_prev;
        logic [15:0] shift;
        logic [15:0] word;
        logic        strobe;
    } dsc_shift_state_t;

    typedef struct packed {
        logic [15:0] left_word;
        logic [15:0] right_word;
        logic [15:0] ctrl_a;
        logic [15:0] ctrl_b;
        logic [7:0]  left_level;
        logic [7:0]  right_level;
        logic [23:0] zero_run;
        logic        zero_muted;
        logic        bck_prev;
        logic        gain_6db;
        logic        update;
    } dsc_top_state_t;

endpackage : dsc_pkg

// >>> rtl/dsc_sync.sv
`timescale 1ns/1ps
module dsc_sync
    import dsc_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_sys_in,
    input  wire logic             nrst_in,
    input  wire logic             clk_en_in,
    // asynchronous levels and their synchronised copies
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    // only stage two reads stage one
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } dsc_sync_state_t;

    dsc_sync_state_t state;
    dsc_sync_state_t next_state;

    always_comb begin
        next_state = state;
        if (clk_en_in) begin
            next_state.meta   = async_in;
            next_state.stable = state.meta;
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.stable;
endmodule : dsc_sync

// >>> rtl/dsc_shift.sv
`timescale 1ns/1ps
`include "dsc_consts.svh"
module dsc_shift
    import dsc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        nrst_in,
    input  wire logic        clk_en_in,
    // synchronised serial port
    input  wire logic        enable_in,
    input  wire logic        shift_clock_in,
    input  wire logic        serial_in,
    input  wire logic        latch_in,
    // latched word
    output logic [15:0]      word_out,
    output logic             word_strobe_out
);
    dsc_shift_state_t state;
    dsc_shift_state_t next_state;

    always_comb begin
        next_state        = state;
        next_state.strobe = 1'b0;
        if (clk_en_in) begin
            next_state.sck_prev   = shift_clock_in;
            next_state.latch_prev = latch_in;
            if (enable_in && shift_clock_in && !state.sck_prev) begin
                next_state.shift = {state.shift[`DSC_WORD_W-2:0], serial_in};
            end
            if (enable_in && latch_in && !state.latch_prev) begin
                next_state.word   = state.shift;
                next_state.strobe = 1'b1;
            end
        end else begin
            next_state.strobe = state.strobe;
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign word_out        = state.word;
    assign word_strobe_out = state.strobe;
endmodule : dsc_shift

// >>> rtl/dsc_regs.sv
// Notes on behaviour
// - serial port works only with mode select high
// - four 16-bit registers loaded serially
// - latch pulse moves shifted word into register
// - bits 10 and 9 pick the register
// - level is half dB per step below 255
// - code zero mutes the channel fully
// - common mode uses left code for both
// - individual mode uses each own code
// - left load bit applies left and right
// - right load bit applies right and left
// - control a bit 0 is soft mute
// - control a bit 1 is de-emphasis
// - disable bit forces bipolar zero output
// - word length and format bits pick format
// - rate bit selects above 52 kHz
// - gain method bit, digital scaling auto 6dB
// - locator bits pick hidden code bit
// - phase and clock output bits, normal default
// - defined defaults after reset
// - zero run of 65536 bit clocks mutes
// - de-emphasis rate bits encode sample rate
// - clock halving and output inversion bits
// - polarity bit swaps left and right phase
`timescale 1ns/1ps
`include "dsc_consts.svh"
module dsc_regs
    import dsc_pkg::*;
#(
    parameter int ZERO_RUN_EDGES = `DSC_ZERO_RUN
) (
    // clock, reset and clock enable
    input  wire logic        clk_sys_in,
    input  wire logic        nrst_in,
    input  wire logic        clk_en_in,
    // control port pins
    input  wire logic        mode_select_in,
    input  wire logic        control_latch_in,
    input  wire logic        control_shift_clock_in,
    input  wire logic        control_serial_in_in,
    // audio side pins
    input  wire logic        serial_bit_clock_in,
    // from the audio path on this clock
    input  wire logic        sample_is_zero_in,
    input  wire logic        peak_extended_in,
    // applied attenuation
    output logic [7:0]       left_level_out,
    output logic [7:0]       right_level_out,
    output logic             left_full_mute_out,
    output logic             right_full_mute_out,
    // control a fields
    output logic             silence_ramp_on_out,
    output logic             deemphasis_on_out,
    output logic             dac_disable_out,
    output logic             high_rate_range_out,
    output logic             gain_method_select_out,
    output logic             gain_scale_6db_out,
    output logic [1:0]       hidden_bit_locator_out,
    // control b fields
    output dsc_fmt_t         data_format_out,
    output logic             word_clock_polarity_out,
    output logic             common_atten_select_out,
    output logic             phase_invert_out,
    output logic             clock_out_halve_out,
    output logic [1:0]       deemph_rate_out,
    output logic             zero_detect_mute_en_out,
    // output forcing and status
    output logic             force_bipolar_zero_out,
    output logic             config_update_out
);
    localparam logic [`DSC_RUN_W-1:0] RUN_LIMIT = `DSC_RUN_W'(ZERO_RUN_EDGES);

    // synchronised pins
    logic [4:0]  pins_sync;
    logic        mode_sync;
    logic        latch_sync;
    logic        sck_sync;
    logic        sdi_sync;
    logic        bck_sync;

    // latched serial word
    logic [15:0] rx_word;
    logic        rx_strobe;
    dsc_sel_t    rx_sel;
    logic        rx_load;
    logic [7:0]  rx_code;

    dsc_top_state_t state;
    dsc_top_state_t next_state;

    dsc_sync #(
        .WIDTH (5)
    ) u_pin_sync (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .clk_en_in  (clk_en_in),
        .async_in   ({serial_bit_clock_in, control_serial_in_in, control_shift_clock_in,
                      control_latch_in, mode_select_in}),
        .sync_out   (pins_sync)
    );

    assign mode_sync  = pins_sync[0];
    assign latch_sync = pins_sync[1];
    assign sck_sync   = pins_sync[2];
    assign sdi_sync   = pins_sync[3];
    assign bck_sync   = pins_sync[4];

    // serial port is ignored while strapped for hardware mode
    dsc_shift u_shift (
        .clk_sys_in      (clk_sys_in),
        .nrst_in         (nrst_in),
        .clk_en_in       (clk_en_in),
        .enable_in       (mode_sync),
        .shift_clock_in  (sck_sync),
        .serial_in       (sdi_sync),
        .latch_in        (latch_sync),
        .word_out        (rx_word),
        .word_strobe_out (rx_strobe)
    );

    assign rx_sel  = dsc_sel_t'(rx_word[`DSC_ADDR_HI:`DSC_ADDR_LO]);
    assign rx_load = rx_word[`DSC_LOAD_BIT];
    assign rx_code = rx_word[`DSC_CODE_HI:`DSC_CODE_LO];

    function automatic logic [7:0] code_of(input logic [15:0] word);
        code_of = word[`DSC_CODE_HI:`DSC_CODE_LO];
    endfunction : code_of

    function automatic dsc_fmt_t decode_format(input logic [15:0] a, input logic [15:0] b);
        logic [1:0] wl;
        wl = {a[`DSC_A_WL_HI], a[`DSC_A_WL_LO]};
        if (!b[`DSC_B_FMT]) begin
            unique case (wl)
                2'b00: decode_format = DSC_FMT_STD16;
                2'b01: decode_format = DSC_FMT_STD20;
                2'b10: decode_format = DSC_FMT_STD24;
                2'b11: decode_format = DSC_FMT_LJ24;
            endcase
        end else begin
            unique case (wl)
                2'b00: decode_format = DSC_FMT_SER16;
                2'b01: decode_format = DSC_FMT_SER24;
                2'b10: decode_format = DSC_FMT_RSVD;
                2'b11: decode_format = DSC_FMT_RSVD;
            endcase
        end
    endfunction : decode_format

    always_comb begin
        next_state        = state;
        next_state.update = 1'b0;
        if (!clk_en_in) begin
            next_state.update = state.update;
        end else begin
            // register writes; reserved bits are stored as received
            if (rx_strobe) begin
                next_state.update = 1'b1;
                unique case (rx_sel)
                    DSC_SEL_LEFT: begin
                        next_state.left_word = rx_word;
                        if (rx_load) begin
                            next_state.left_level = rx_code;
                            if (state.ctrl_b[`DSC_B_COMMON]) begin
                                next_state.right_level = rx_code;
                            end else begin
                                next_state.right_level = code_of(state.right_word);
                            end
                        end
                    end
                    DSC_SEL_RIGHT: begin
                        next_state.right_word = rx_word;
                        if (rx_load) begin
                            next_state.left_level = code_of(state.left_word);
                            if (state.ctrl_b[`DSC_B_COMMON]) begin
                                next_state.right_level = code_of(state.left_word);
                            end else begin
                                next_state.right_level = rx_code;
                            end
                        end
                    end
                    DSC_SEL_CTRLA: begin
                        next_state.ctrl_a = rx_word;
                    end
                    DSC_SEL_CTRLB: begin
                        next_state.ctrl_b = rx_word;
                    end
                endcase
            end

            // zero run counted in bit clock rising edges
            next_state.bck_prev = bck_sync;
            if (!sample_is_zero_in) begin
                next_state.zero_run   = '0;
                next_state.zero_muted = 1'b0;
            end else if (bck_sync && !state.bck_prev) begin
                if (state.zero_run < RUN_LIMIT) begin
                    next_state.zero_run = state.zero_run + `DSC_RUN_W'(1);
                end
                if (state.zero_run + `DSC_RUN_W'(1) >= RUN_LIMIT) begin
                    next_state.zero_muted = 1'b1;
                end
            end

            // digital scaling drops plain and non-peak-extended material by 6 dB
            next_state.gain_6db = !state.ctrl_a[`DSC_A_GAIN] && !peak_extended_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state             <= '0;
            state.left_word   <= `DSC_RST_LEFT;
            state.right_word  <= `DSC_RST_RIGHT;
            state.ctrl_a      <= `DSC_RST_CTRL_A;
            state.ctrl_b      <= `DSC_RST_CTRL_B;
            state.left_level  <= `DSC_RST_LEVEL;
            state.right_level <= `DSC_RST_LEVEL;
        end else begin
            state <= next_state;
        end
    end

    // level code steps 0.5 dB below code ff; the attenuator applies it
    assign left_level_out          = state.left_level;
    // common mode also covers a switch made after the last load
    assign right_level_out         = state.ctrl_b[`DSC_B_COMMON] ? state.left_level
                                                                 : state.right_level;
    assign left_full_mute_out      = (left_level_out == `DSC_MUTE_CODE);
    assign right_full_mute_out     = (right_level_out == `DSC_MUTE_CODE);

    assign silence_ramp_on_out     = state.ctrl_a[`DSC_A_MUTE];
    assign deemphasis_on_out       = state.ctrl_a[`DSC_A_DEEMPH];
    assign dac_disable_out         = state.ctrl_a[`DSC_A_DISABLE];
    assign high_rate_range_out     = state.ctrl_a[`DSC_A_RATE];
    assign gain_method_select_out  = state.ctrl_a[`DSC_A_GAIN];
    assign gain_scale_6db_out      = state.gain_6db;
    // code 10 is reserved; it is passed on unchanged
    assign hidden_bit_locator_out  = {state.ctrl_a[`DSC_A_HID_HI], state.ctrl_a[`DSC_A_HID_LO]};

    assign data_format_out         = decode_format(state.ctrl_a, state.ctrl_b);
    // polarity only means something for standard and left-justified data
    assign word_clock_polarity_out = state.ctrl_b[`DSC_B_POL]
                                     && !state.ctrl_b[`DSC_B_FMT];
    assign common_atten_select_out = state.ctrl_b[`DSC_B_COMMON];
    assign phase_invert_out        = state.ctrl_b[`DSC_B_PHASE];
    assign clock_out_halve_out     = state.ctrl_b[`DSC_B_CKO];
    assign deemph_rate_out         = {state.ctrl_b[`DSC_B_SF_HI], state.ctrl_b[`DSC_B_SF_LO]};
    assign zero_detect_mute_en_out = state.ctrl_b[`DSC_B_ZD];

    // disable wins regardless of data; zero mute needs its enable
    assign force_bipolar_zero_out  = state.ctrl_a[`DSC_A_DISABLE]
                                     || (state.ctrl_b[`DSC_B_ZD] && state.zero_muted);
    assign config_update_out       = state.update;
endmodule : dsc_regs

// >>> verification/dsc_regs_properties.sv
`timescale 1ns/1ps
module dsc_regs_properties
    import dsc_pkg::*;
(
    // clock, reset and pins
    input wire logic       clk_sys_in,
    input wire logic       nrst_in,
    input wire logic       clk_en_in,
    input wire logic       mode_select_in,
    input wire logic       control_latch_in,
    input wire logic       sample_is_zero_in,
    input wire logic       peak_extended_in,
    // design outputs
    input wire logic [7:0] left_level_out,
    input wire logic [7:0] right_level_out,
    input wire logic       left_full_mute_out,
    input wire logic       right_full_mute_out,
    input wire logic       gain_method_select_out,
    input wire logic       gain_scale_6db_out,
    input wire dsc_fmt_t   data_format_out,
    input wire logic       word_clock_polarity_out,
    input wire logic       common_atten_select_out,
    input wire logic       dac_disable_out,
    input wire logic       zero_detect_mute_en_out,
    input wire logic       force_bipolar_zero_out,
    input wire logic       config_update_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    // three cycles of mode high let the synchroniser see it before the latch edge
    sequence s_latch;
        (mode_select_in && clk_en_in) [*3] ##0 $rose(control_latch_in);
    endsequence
    sequence s_answer;
        ##4 config_update_out ##1 !config_update_out;
    endsequence
    property p_latch; s_latch |-> s_answer; endproperty
    property p_mode_off; !mode_select_in [*8] |-> !config_update_out; endproperty
    property p_hold; $changed(left_level_out) || $changed(right_level_out) |-> config_update_out; endproperty
    property p_mute;
        left_full_mute_out == (left_level_out == 8'h00) && right_full_mute_out == (right_level_out == 8'h00);
    endproperty
    property p_common; common_atten_select_out |-> right_level_out == left_level_out; endproperty
    property p_disable; dac_disable_out |-> force_bipolar_zero_out; endproperty
    property p_no_zd; !zero_detect_mute_en_out && !dac_disable_out |-> !force_bipolar_zero_out; endproperty
    property p_zero_clear; !sample_is_zero_in |=> force_bipolar_zero_out == dac_disable_out; endproperty
    property p_gain;
        1'h1 |=> gain_scale_6db_out == $past(!gain_method_select_out && !peak_extended_in);
    endproperty
    property p_pol; word_clock_polarity_out |-> !data_format_out[2]; endproperty
    a_latch: assert property (p_latch) else $error("no single update pulse after latch");
    a_mode_off: assert property (p_mode_off) else $error("update while port disabled");
    a_hold: assert property (p_hold) else $error("level moved without a write");
    a_mute: assert property (p_mute) else $error("full mute flag wrong");
    a_common: assert property (p_common) else $error("common level differs");
    a_disable: assert property (p_disable) else $error("disable did not force zero");
    a_no_zd: assert property (p_no_zd) else $error("forced zero with detect off");
    a_zero_clear: assert property (p_zero_clear) else $error("zero mute not cleared");
    a_gain: assert property (p_gain) else $error("gain decision wrong");
    a_pol: assert property (p_pol) else $error("polarity in serial format");
endmodule : dsc_regs_properties

// >>> verification/dsc_host.sv
`timescale 1ns/1ps
module dsc_host (
    // pacing clock
    input  wire logic clk_sys_in,
    // three-wire control port
    output logic      control_latch_out,
    output logic      control_shift_clock_out,
    output logic      control_serial_out
);
    initial begin
        control_latch_out = 1'h0;
        control_shift_clock_out = 1'h0;
        control_serial_out = 1'h0;
    end
    // three system cycles low and five high (four for the last bit) on the shift clock keep every pin phase at 120 ns or more
    task automatic send(input logic [15:0] w);
        logic [15:0] v;
        v = w & 16'h07ff;
        for (int i = 15; i >= 0; i--) begin
            @(negedge clk_sys_in);
            control_serial_out = v[i];
            control_shift_clock_out = 1'h0;
            repeat (3) @(negedge clk_sys_in);
            control_shift_clock_out = 1'h1;
            repeat (4) @(negedge clk_sys_in);
        end
        control_shift_clock_out = 1'h0;
        // the data line no longer shows the last bit once the word is in
        control_serial_out = ~v[0];
        repeat (4) @(negedge clk_sys_in);
        control_latch_out = 1'h1;
        repeat (4) @(negedge clk_sys_in);
        control_latch_out = 1'h0;
    endtask : send
endmodule : dsc_host

// >>> verification/dsc_regs_bench.sv
`timescale 1ns/1ps
`include "dsc_consts.svh"
module dsc_regs_bench;
    import dsc_pkg::*;
    localparam int ZR = 8;
    logic       clk_sys_in, nrst_in, clk_en_in, mode_select_in, serial_bit_clock_in;
    logic       sample_is_zero_in, peak_extended_in, control_latch_in, control_shift_clock_in;
    logic       control_serial_in_in, left_full_mute_out, right_full_mute_out, silence_ramp_on_out;
    logic       deemphasis_on_out, dac_disable_out, high_rate_range_out, gain_method_select_out;
    logic       gain_scale_6db_out, word_clock_polarity_out, common_atten_select_out, phase_invert_out;
    logic       clock_out_halve_out, zero_detect_mute_en_out, force_bipolar_zero_out, config_update_out;
    logic [7:0] left_level_out, right_level_out, ll, rl;
    logic [1:0] hidden_bit_locator_out, deemph_rate_out;
    dsc_fmt_t   data_format_out;
    logic [15:0] rg [4];
    logic [15:0] q [$];
    logic        zm;
    int          miscompares, cmp_count;

    dsc_regs #(.ZERO_RUN_EDGES(ZR)) i_dsc_regs (.clk_sys_in, .nrst_in, .clk_en_in, .mode_select_in,
        .control_latch_in, .control_shift_clock_in, .control_serial_in_in, .serial_bit_clock_in,
        .sample_is_zero_in, .peak_extended_in, .left_level_out, .right_level_out, .left_full_mute_out,
        .right_full_mute_out, .silence_ramp_on_out, .deemphasis_on_out, .dac_disable_out,
        .high_rate_range_out, .gain_method_select_out, .gain_scale_6db_out, .hidden_bit_locator_out,
        .data_format_out, .word_clock_polarity_out, .common_atten_select_out, .phase_invert_out,
        .clock_out_halve_out, .deemph_rate_out, .zero_detect_mute_en_out, .force_bipolar_zero_out,
        .config_update_out);
    dsc_host i_dsc_host (.clk_sys_in, .control_latch_out(control_latch_in),
        .control_shift_clock_out(control_shift_clock_in), .control_serial_out(control_serial_in_in));

    initial begin
        clk_sys_in = 1'h0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    // offset so bit clock edges never meet system clock edges
    initial begin
        serial_bit_clock_in = 1'h0;
        #7;
        forever #160 serial_bit_clock_in = ~serial_bit_clock_in;
    end
    initial begin
        #2000000;
        miscompares++;
        close_out();
    end

    task automatic close_out;
        if (miscompares == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic chk_all;
        logic [2:0] f;
        f = rg[3][0] ? (rg[2][4] ? DSC_FMT_RSVD : {2'h2, rg[2][3]}) : {1'h0, rg[2][4:3]};
        chk(left_level_out, ll);
        chk(right_level_out, rg[3][2] ? ll : rl);
        chk(left_full_mute_out, ll == 8'h00);
        chk(right_full_mute_out, (rg[3][2] ? ll : rl) == 8'h00);
        chk(silence_ramp_on_out, rg[2][0]);
        chk(deemphasis_on_out, rg[2][1]);
        chk(dac_disable_out, rg[2][2]);
        chk(high_rate_range_out, rg[2][5]);
        chk(gain_method_select_out, rg[2][6]);
        chk(gain_scale_6db_out, !rg[2][6] && !peak_extended_in);
        chk(hidden_bit_locator_out, rg[2][8:7]);
        chk(data_format_out, f);
        chk(word_clock_polarity_out, rg[3][1] && !rg[3][0]);
        chk(common_atten_select_out, rg[3][2]);
        chk(phase_invert_out, rg[3][4]);
        chk(clock_out_halve_out, rg[3][5]);
        chk(deemph_rate_out, rg[3][7:6]);
        chk(zero_detect_mute_en_out, rg[3][8]);
        chk(force_bipolar_zero_out, rg[2][2] || (rg[3][8] && zm));
    endtask : chk_all

    task automatic do_reset;
        @(negedge clk_sys_in);
        nrst_in = 1'h0;
        repeat (6) @(negedge clk_sys_in);
        nrst_in = 1'h1;
        repeat (2) @(negedge clk_sys_in);
        rg = '{`DSC_RST_LEFT, `DSC_RST_RIGHT, `DSC_RST_CTRL_A, `DSC_RST_CTRL_B};
        ll = `DSC_RST_LEVEL;
        rl = `DSC_RST_LEVEL;
        zm = 1'h0;
        chk_all();
    endtask : do_reset

    task automatic wr(input logic [15:0] w);
        logic on;
        on = mode_select_in && clk_en_in;
        i_dsc_host.send(w);
        if (on) begin
            rg[w[10:9]] = w;
            if (w[8] && w[10:9] == 2'h0) begin
                ll = w[7:0];
                rl = rg[3][2] ? w[7:0] : rg[1][7:0];
            end
            if (w[8] && w[10:9] == 2'h1) begin
                ll = rg[0][7:0];
                rl = rg[3][2] ? rg[0][7:0] : w[7:0];
            end
        end
        @(negedge clk_sys_in);
        chk_all();
    endtask : wr

    initial begin
        nrst_in = 1'h0;
        clk_en_in = 1'h1;
        mode_select_in = 1'h1;
        sample_is_zero_in = 1'h0;
        peak_extended_in = 1'h0;
        miscompares = 0;
        cmp_count = 0;
        void'($urandom(49));
        do_reset();
        // load and common cases, then locator set for 20-bit words
        q = '{16'h0100, 16'h03fe, 16'h0001, 16'h0204, 16'h0604, 16'h01ff, 16'h0305, 16'h0600, 16'h0488};
        foreach (q[i]) wr(q[i]);
        for (int f = 0; f < 8; f++) begin
            wr(16'h0400 | 16'(f[2:1]) << 3);
            wr(16'h0600 | 16'(f[0]));
        end
        repeat (40) begin
            peak_extended_in = 1'($urandom);
            wr({5'h00, 2'($urandom), 9'($urandom)});
        end
        for (int k = 0; k < 2; k++) begin
            if (k == 0) mode_select_in = 1'h0;
            else clk_en_in = 1'h0;
            repeat (3) @(negedge clk_sys_in);
            wr({5'h00, 2'($urandom), 9'($urandom)});
            mode_select_in = 1'h1;
            clk_en_in = 1'h1;
            repeat (3) @(negedge clk_sys_in);
        end
        wr(16'h0400);
        wr(16'h0700);
        @(negedge serial_bit_clock_in);
        @(negedge clk_sys_in);
        sample_is_zero_in = 1'h1;
        repeat (ZR - 1) @(posedge serial_bit_clock_in);
        repeat (5) @(negedge clk_sys_in);
        chk_all();
        @(posedge serial_bit_clock_in);
        repeat (5) @(negedge clk_sys_in);
        zm = 1'h1;
        chk_all();
        sample_is_zero_in = 1'h0;
        zm = 1'h0;
        repeat (2) @(negedge clk_sys_in);
        chk_all();
        do_reset();
        close_out();
    end
endmodule : dsc_regs_bench

bind dsc_regs dsc_regs_properties i_dsc_regs_properties (.clk_sys_in, .nrst_in, .clk_en_in, .mode_select_in,
    .control_latch_in, .sample_is_zero_in, .peak_extended_in, .left_level_out, .right_level_out,
    .left_full_mute_out, .right_full_mute_out, .gain_method_select_out, .gain_scale_6db_out,
    .data_format_out, .word_clock_polarity_out, .common_atten_select_out, .dac_disable_out,
    .zero_detect_mute_en_out, .force_bipolar_zero_out, .config_update_out);
